// file: src/cki_accessory_irq.sv
// Notes on behaviour
// - enable reads at 1D-1F, write/set/clear
// - enabled ID-to-floating edge raises alt interrupt
// - enabled floating-to-driven edge raises alt interrupt
// - unimplemented and reserved bits read zero; vendor register bit 5 is writable and reads back
// - measure-done interrupt enabled by either enable
// - state bit 0 shows ID floating now
// - state bits 5:3 give measured code
// - done flag sets when measurement completes
// - only vendor register read clears done
// - event register read returns and clears
// - event bit 0 on enabled ID edge
// - event bit 3 on enabled done rise
// - vendor range reached by immediate accesses
// - go starts measurement, clears when finished
`default_nettype none
module cki_accessory_irq #(
    parameter int MEAS_CYC = cki_pkg::CKI_MEAS_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ulpi_clk,
    input wire logic ulpi_rst_n,
    input wire logic [7:0] ulpi_data_in,
    output logic [7:0] ulpi_data_out,
    output logic ulpi_data_oe,
    output logic ulpi_dir,
    output logic ulpi_nxt,
    input wire logic ulpi_stp,
    input wire logic ident_open_pin,
    input wire logic [2:0] rid_code_pin
);
    import cki_pkg::*;

    cki_meas_if mif ();
    cki_link_s s, n;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // write, set or clear of a register, by offset from its base
    function automatic logic [7:0] cki_upd(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [1:0] sel,
        input logic [7:0] msk
    );
        logic [7:0] v;
        v = wd & msk;
        case (sel)
            2'h0: cki_upd = (old & ~msk) | v;
            2'h1: cki_upd = old | v;
            2'h2: cki_upd = old & ~v;
            default: cki_upd = old;
        endcase
    endfunction

    function automatic logic in_rng(
        input logic [5:0] a,
        input logic [5:0] lo,
        input logic [5:0] hi
    );
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // events of this cycle
    // ------------------------------------------------------------
    logic rise, fall, done_evt, done_rise, rid_en, rd_take, wr_go;
    logic ev_new;
    logic is_ena, is_vnd, is_vnd_reg;
    logic [7:0] rdata;

    assign rise = s.open_sync && !s.open_prev;
    assign fall = !s.open_sync && s.open_prev;
    assign done_evt = s.dn_sync != s.dn_prev;
    assign done_rise = done_evt && !s.done;
    assign rid_en = s.ena[CKI_ENA_RID_BIT] | s.vnd[CKI_VND_IEN_BIT];
    assign rd_take = s.st == CKI_RD_DATA;
    assign wr_go = (s.st == CKI_WR_END) && ulpi_stp;
    assign is_ena = in_rng(s.addr, CKI_ADDR_ENA_WR, CKI_ADDR_ENA_CLR);
    assign is_vnd = in_rng(s.addr, CKI_ADDR_VND_LO, CKI_ADDR_VND_HI);
    assign is_vnd_reg = in_rng(s.addr, CKI_ADDR_VND_WR, CKI_ADDR_VND_CLR);
    assign ev_new = (rise && s.ena[CKI_ENA_RISE_BIT])
        || (fall && s.ena[CKI_ENA_FALL_BIT])
        || (done_rise && rid_en);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // every unmapped address, vendor range included, reads zero
    always_comb begin
        rdata = 8'h00;
        if (is_ena) begin
            rdata = s.ena;
        end else if (s.addr == CKI_ADDR_STATE) begin
            rdata[CKI_ST_OPEN_BIT] = s.open_sync;
            rdata[CKI_ST_CODE_LSB +: 3] = s.code;
            rdata[CKI_ST_DONE_BIT] = s.done;
        end else if (s.addr == CKI_ADDR_EVENTS) begin
            rdata[CKI_EV_OPEN_BIT] = s.ev_open;
            rdata[CKI_EV_RID_BIT] = s.ev_rid;
        end else if (is_vnd_reg) begin
            rdata = s.vnd;
            rdata[CKI_VND_CODE_LSB +: 3] = s.code;
            rdata[CKI_VND_DONE_BIT] = s.done;
        end
    end

    // ------------------------------------------------------------
    // next state of the link side
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.open_meta = ident_open_pin;
        n.open_sync = s.open_meta;
        n.open_prev = s.open_sync;
        n.dn_meta = mif.done_tgl;
        n.dn_sync = s.dn_meta;
        n.dn_prev = s.dn_sync;
        // completion: clear go first so a same-cycle set still wins
        if (done_evt) begin
            n.code = mif.code;
            n.vnd[CKI_VND_GO_BIT] = 1'b0;
        end
        // register writes, committed on stop
        if (wr_go && is_ena) begin
            n.ena = cki_upd(s.ena, s.wdata,
                2'(s.addr - CKI_ADDR_ENA_WR), CKI_ENA_WMASK);
        end
        if (wr_go && is_vnd_reg) begin
            n.vnd = cki_upd(n.vnd, s.wdata,
                2'(s.addr - CKI_ADDR_VND_WR), CKI_VND_WMASK);
            if (!s.vnd[CKI_VND_GO_BIT] && n.vnd[CKI_VND_GO_BIT]) begin
                n.go_tgl = ~s.go_tgl;
            end
        end
        // read side effects, then sets so a new event is never lost
        if (rd_take && is_vnd_reg) begin
            n.done = 1'b0;
        end
        if (rd_take && s.addr == CKI_ADDR_EVENTS) begin
            n.ev_open = 1'b0;
            n.ev_rid = 1'b0;
        end
        if (done_evt) begin
            n.done = 1'b1;
        end
        if ((rise && s.ena[CKI_ENA_RISE_BIT])
            || (fall && s.ena[CKI_ENA_FALL_BIT])) begin
            n.ev_open = 1'b1;
        end
        if (done_rise && rid_en) begin
            n.ev_rid = 1'b1;
        end
        // link protocol
        n.nxt = 1'b0;
        case (s.st)
            CKI_IDLE: begin
                if (ulpi_data_in[7:6] == CKI_CMD_REGWR) begin
                    n.addr = ulpi_data_in[5:0];
                    n.nxt = 1'b1;
                    n.st = CKI_WR_WAIT;
                end else if (ulpi_data_in[7:6] == CKI_CMD_REGRD) begin
                    n.addr = ulpi_data_in[5:0];
                    n.nxt = 1'b1;
                    n.st = CKI_RD_TURN;
                end else if (ulpi_data_in == 8'h00 && s.alt_pend) begin
                    n.dir = 1'b1;
                    n.st = CKI_RX_TURN;
                end
            end
            CKI_WR_WAIT: begin
                n.st = CKI_WR_DATA;
            end
            CKI_WR_DATA: begin
                n.wdata = ulpi_data_in;
                n.nxt = 1'b1;
                n.st = CKI_WR_END;
            end
            CKI_WR_END: begin
                if (ulpi_stp) begin
                    n.st = CKI_IDLE;
                end
            end
            CKI_RD_TURN: begin
                n.dir = 1'b1;
                n.st = CKI_RD_DATA;
            end
            CKI_RD_DATA: begin
                n.dout = rdata;
                n.oe = 1'b1;
                n.st = CKI_RD_DONE;
            end
            CKI_RX_TURN: begin
                n.dout = 8'h00;
                n.dout[CKI_RXCMD_ALT_BIT] = 1'b1;
                n.oe = 1'b1;
                n.alt_pend = 1'b0;
                n.st = CKI_RX_DONE;
            end
            CKI_RD_DONE, CKI_RX_DONE: begin
                n.dir = 1'b0;
                n.oe = 1'b0;
                n.dout = 8'h00;
                n.st = CKI_IDLE;
            end
            default: begin
                n.st = CKI_IDLE;
            end
        endcase
        if (ev_new) begin
            n.alt_pend = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register, link clock
    // ------------------------------------------------------------
    always_ff @(posedge ulpi_clk) begin
        if (!ulpi_rst_n) begin
            s <= '0;
            s.st <= CKI_IDLE;
            s.ena <= CKI_ENA_RST;
            s.vnd <= CKI_VND_RST;
            s.code <= CKI_CODE_RST;
        end else begin
            s <= n;
        end
    end

    assign ulpi_data_out = s.dout;
    assign ulpi_data_oe = s.oe;
    assign ulpi_dir = s.dir;
    assign ulpi_nxt = s.nxt;
    assign mif.go_tgl = s.go_tgl;

    // measurement timer runs on the core clock
    cki_measure #(.MEAS_CYC(MEAS_CYC)) u_meas (
        .clk(clk),
        .rst_n(rst_n),
        .rid_code_pin(rid_code_pin),
        .mif(mif)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ulpi_clk);
    endclocking
    default disable iff (!ulpi_rst_n);

    sequence s_rd_acc;
        s.st == CKI_IDLE && ulpi_data_in[7:6] == CKI_CMD_REGRD;
    endsequence
    sequence s_rd_turn;
        ulpi_nxt && !ulpi_dir ##1 ulpi_dir && !ulpi_data_oe;
    endsequence
    sequence s_rd_end;
        ulpi_dir && ulpi_data_oe ##1 !ulpi_dir && !ulpi_data_oe;
    endsequence

    property p_rd_seq;
        s_rd_acc |=> s_rd_turn ##1 s_rd_end;
    endproperty
    a_rd_seq: assert property (p_rd_seq)
        else $error("register read turnaround out of order");

    property p_ena_wr;
        wr_go && s.addr == CKI_ADDR_ENA_WR
            |=> s.ena == ($past(s.wdata) & CKI_ENA_WMASK);
    endproperty
    a_ena_wr: assert property (p_ena_wr)
        else $error("enable write not stored");

    property p_ena_set;
        wr_go && s.addr == CKI_ADDR_ENA_SET
            |=> s.ena == ($past(s.ena) | ($past(s.wdata) & CKI_ENA_WMASK));
    endproperty
    a_ena_set: assert property (p_ena_set)
        else $error("enable set did not OR in");

    property p_ena_clr;
        wr_go && s.addr == CKI_ADDR_ENA_CLR
            |=> s.ena == ($past(s.ena) & ~$past(s.wdata));
    endproperty
    a_ena_clr: assert property (p_ena_clr)
        else $error("enable clear wrong");

    property p_rsvd_zero;
        (s.ena & ~CKI_ENA_WMASK) == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("unimplemented enable bit set");

    property p_open_evt;
        rise && s.ena[CKI_ENA_RISE_BIT] |=> s.ev_open ##[1:12] s.alt_pend;
    endproperty
    a_open_evt: assert property (p_open_evt)
        else $error("floating edge not latched");

    property p_rid_evt;
        done_rise && rid_en |=> s.ev_rid && s.done && !s.vnd[CKI_VND_GO_BIT];
    endproperty
    a_rid_evt: assert property (p_rid_evt)
        else $error("measurement completion not latched");

    property p_alt_out;
        ev_new && s.st == CKI_IDLE && !s.alt_pend
            |-> ##[1:12] (ulpi_dir && ulpi_data_oe
                && ulpi_data_out[CKI_RXCMD_ALT_BIT]);
    endproperty
    a_alt_out: assert property (p_alt_out)
        else $error("alt interrupt not sent");

    property p_state_keep;
        rd_take && s.addr == CKI_ADDR_STATE && !done_evt
            |=> s.done == $past(s.done);
    endproperty
    a_state_keep: assert property (p_state_keep)
        else $error("state read disturbed done flag");

    property p_vnd_clr;
        rd_take && is_vnd_reg && !done_evt |=> !s.done;
    endproperty
    a_vnd_clr: assert property (p_vnd_clr)
        else $error("vendor read did not clear done");

    property p_ev_clr;
        rd_take && s.addr == CKI_ADDR_EVENTS && !ev_new
            |=> !s.ev_open && !s.ev_rid;
    endproperty
    a_ev_clr: assert property (p_ev_clr)
        else $error("event read did not clear");

endmodule
`default_nettype wire

// file: src/cki_pkg.sv
`default_nettype none
package cki_pkg;

    // ------------------------------------------------------------
    // register addresses (6-bit immediate address space)
    // ------------------------------------------------------------
    localparam logic [5:0] CKI_ADDR_ENA_WR = 6'h1D;
    localparam logic [5:0] CKI_ADDR_ENA_SET = 6'h1E;
    localparam logic [5:0] CKI_ADDR_ENA_CLR = 6'h1F;
    localparam logic [5:0] CKI_ADDR_STATE = 6'h20;
    localparam logic [5:0] CKI_ADDR_EVENTS = 6'h21;
    localparam logic [5:0] CKI_ADDR_VND_WR = 6'h36;
    localparam logic [5:0] CKI_ADDR_VND_SET = 6'h37;
    localparam logic [5:0] CKI_ADDR_VND_CLR = 6'h38;
    localparam logic [5:0] CKI_ADDR_VND_LO = 6'h30;
    localparam logic [5:0] CKI_ADDR_VND_HI = 6'h3F;

    // ------------------------------------------------------------
    // field positions, write masks and reset values
    // ------------------------------------------------------------
    localparam int CKI_ENA_RISE_BIT = 0;
    localparam int CKI_ENA_FALL_BIT = 1;
    localparam int CKI_ENA_RID_BIT = 5;
    localparam int CKI_ST_OPEN_BIT = 0;
    localparam int CKI_ST_CODE_LSB = 3;
    localparam int CKI_ST_DONE_BIT = 6;
    localparam int CKI_EV_OPEN_BIT = 0;
    localparam int CKI_EV_RID_BIT = 3;
    localparam int CKI_VND_CODE_LSB = 0;
    localparam int CKI_VND_DONE_BIT = 3;
    localparam int CKI_VND_GO_BIT = 4;
    localparam int CKI_VND_IEN_BIT = 6;
    localparam int CKI_RXCMD_ALT_BIT = 7;
    localparam logic [7:0] CKI_ENA_WMASK = 8'h23;
    localparam logic [7:0] CKI_VND_WMASK = 8'h70;
    localparam logic [7:0] CKI_ENA_RST = 8'h00;
    localparam logic [7:0] CKI_VND_RST = 8'h00;
    localparam logic [2:0] CKI_CODE_RST = 3'h0;

    // ------------------------------------------------------------
    // link command codes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] CKI_CMD_REGWR = 2'h2;
    localparam logic [1:0] CKI_CMD_REGRD = 2'h3;
    localparam int CKI_MEAS_NS = 282000;
    localparam int CKI_CLK_NS = 25;
    localparam int CKI_MEAS_CYC = CKI_MEAS_NS / CKI_CLK_NS;
    localparam int CKI_CNT_W = 14;

    typedef enum logic [3:0] {
        CKI_IDLE, CKI_WR_WAIT, CKI_WR_DATA, CKI_WR_END, CKI_RD_TURN,
        CKI_RD_DATA, CKI_RD_DONE, CKI_RX_TURN, CKI_RX_DONE
    } cki_link_e;

    typedef struct packed {
        cki_link_e st;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] dout;
        logic oe;
        logic dir;
        logic nxt;
        logic [7:0] ena;
        logic [7:0] vnd;
        logic done;
        logic [2:0] code;
        logic ev_open;
        logic ev_rid;
        logic alt_pend;
        logic open_meta;
        logic open_sync;
        logic open_prev;
        logic dn_meta;
        logic dn_sync;
        logic dn_prev;
        logic go_tgl;
    } cki_link_s;

    typedef struct packed {
        logic go_meta;
        logic go_sync;
        logic go_prev;
        logic busy;
        logic [CKI_CNT_W-1:0] cnt;
        logic [2:0] code_meta;
        logic [2:0] code_sync;
        logic [2:0] code;
        logic done_tgl;
    } cki_meas_s;

endpackage
`default_nettype wire

// file: src/cki_meas_if.sv
`default_nettype none
interface cki_meas_if;
    // go toggles from the link side, done toggles back with code stable
    logic go_tgl;
    logic done_tgl;
    logic [2:0] code;
    modport ctl (output go_tgl, input done_tgl, input code);
    modport meas (input go_tgl, output done_tgl, output code);
endinterface
`default_nettype wire

// file: src/cki_measure.sv
`default_nettype none
module cki_measure #(
    parameter int MEAS_CYC = cki_pkg::CKI_MEAS_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] rid_code_pin,
    cki_meas_if.meas mif
);
    import cki_pkg::*;

    cki_meas_s s, n;

    // ------------------------------------------------------------
    // measurement timer on the core clock
    // ------------------------------------------------------------
    // a go toggle seen while busy is dropped: one measurement at a time
    always_comb begin
        n = s;
        n.go_meta = mif.go_tgl;
        n.go_sync = s.go_meta;
        n.go_prev = s.go_sync;
        n.code_meta = rid_code_pin;
        n.code_sync = s.code_meta;
        if (s.busy) begin
            if (s.cnt == CKI_CNT_W'(MEAS_CYC - 1)) begin
                n.busy = 1'b0;
                n.cnt = '0;
                n.code = s.code_sync; // code updates on the same edge as the toggle
                n.done_tgl = ~s.done_tgl;
            end else begin
                n.cnt = s.cnt + CKI_CNT_W'(1);
            end
        end else if (s.go_sync != s.go_prev) begin
            n.busy = 1'b1;
            n.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign mif.done_tgl = s.done_tgl;
    assign mif.code = s.code;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_meas_end;
        @(posedge clk) disable iff (!rst_n)
        s.busy && s.cnt == CKI_CNT_W'(MEAS_CYC - 1)
            |=> !s.busy && (s.done_tgl != $past(s.done_tgl));
    endproperty
    a_meas_end: assert property (p_meas_end)
        else $error("measurement did not finish on its last count");

endmodule
`default_nettype wire

// file: dv/cki_link_model.sv
`default_nettype none
module cki_link_model (
    input wire logic ulpi_clk,
    input wire logic ulpi_dir,
    input wire logic ulpi_nxt,
    input wire logic ulpi_data_oe,
    input wire logic [7:0] ulpi_data_out,
    output var logic [7:0] ulpi_data_in,
    output var logic ulpi_stp
);
    timeunit 1ns;
    timeprecision 100ps;
    import cki_pkg::*;

    int alt_cnt = 0;
    int miss = 0;
    logic reading = 1'b0;

    initial begin
        ulpi_data_in = 8'h00;
        ulpi_stp = 1'b0;
    end

    // ------------------------------------------------------------
    // alt interrupt counting
    // ------------------------------------------------------------
    // any byte the block drives outside a read is a receive command
    always @(posedge ulpi_clk) begin
        if (ulpi_dir === 1'b1 && ulpi_data_oe === 1'b1 && !reading &&
            ulpi_data_out[CKI_RXCMD_ALT_BIT] === 1'b1) begin
            alt_cnt++;
        end
    end

    // ------------------------------------------------------------
    // immediate register accesses
    // ------------------------------------------------------------
    // wait up to 20 edges for the block to release the bus, then up to 8 for nxt
    task automatic send_cmd(input logic [7:0] cmd);
        int n;
        n = 0;
        while (ulpi_dir !== 1'b0 && n < 20) begin
            @(posedge ulpi_clk);
            #2;
            n++;
        end
        ulpi_data_in = cmd;
        n = 0;
        do begin
            @(posedge ulpi_clk);
            n++;
        end while (ulpi_nxt !== 1'b1 && n < 8);
        if (ulpi_nxt !== 1'b1) miss++;
        #2;
    endtask

    // data byte, then stop held until the second nxt is seen
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] v);
        int n;
        send_cmd({CKI_CMD_REGWR, a});
        ulpi_data_in = v;
        @(posedge ulpi_clk);
        #2;
        ulpi_stp = 1'b1;
        n = 0;
        do begin
            @(posedge ulpi_clk);
            n++;
        end while (ulpi_nxt !== 1'b1 && n < 8);
        if (ulpi_nxt !== 1'b1) miss++;
        #2;
        ulpi_stp = 1'b0;
        ulpi_data_in = 8'h00;
        // one idle edge, so a pending rxcmd is not starved by the next access
        @(posedge ulpi_clk);
        #2;
    endtask

    // released bus shows the inverse, not a stale command byte
    task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
        int n;
        reading = 1'b1;
        send_cmd({CKI_CMD_REGRD, a});
        ulpi_data_in = ~{CKI_CMD_REGRD, a};
        n = 0;
        do begin
            @(posedge ulpi_clk);
            n++;
        end while (ulpi_data_oe !== 1'b1 && n < 8);
        if (ulpi_data_oe !== 1'b1) miss++;
        d = ulpi_data_out;
        #2;
        ulpi_data_in = 8'h00;
        reading = 1'b0;
        @(posedge ulpi_clk);
        #2;
    endtask
endmodule
`default_nettype wire

// file: dv/cki_accessory_irq_tb_top.sv
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[ERR] %s exp %h got %h", nm, exp, got); \
        end \
    end
module cki_accessory_irq_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cki_pkg::*;

    localparam int MEAS = 20;
    logic clk = 1'b0;
    logic ulpi_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ulpi_rst_n = 1'b0;
    logic ident_open_pin = 1'b0;
    logic [2:0] rid_code_pin = 3'h0;
    logic [7:0] ulpi_data_in;
    logic [7:0] ulpi_data_out;
    logic ulpi_data_oe;
    logic ulpi_dir;
    logic ulpi_nxt;
    logic ulpi_stp;
    int err_total = 0;
    int comparisons = 0;
    int alt_exp = 0;

    // ------------------------------------------------------------
    // clocks, design and link partner
    // ------------------------------------------------------------
    // core 25 ns, link 80 ns; half periods keep edges apart
    always #12.5 clk = ~clk;
    always #40 ulpi_clk = ~ulpi_clk;

    cki_accessory_irq #(.MEAS_CYC(MEAS)) dut (
        .clk(clk), .rst_n(rst_n), .ulpi_clk(ulpi_clk),
        .ulpi_rst_n(ulpi_rst_n), .ulpi_data_in(ulpi_data_in),
        .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
        .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp),
        .ident_open_pin(ident_open_pin), .rid_code_pin(rid_code_pin)
    );

    cki_link_model link (
        .ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
        .ulpi_data_oe(ulpi_data_oe), .ulpi_data_out(ulpi_data_out),
        .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        link.reg_rd(a, d);
        `CHK($sformatf("reg %h", a), e, d)
    endtask

    // one receive command per latched event, none otherwise
    task automatic chk_alt(input int inc);
        alt_exp += inc;
        `CHK("alt_int count", alt_exp, link.alt_cnt)
    endtask

    // pin edges need three link edges of sync plus the rxcmd
    task automatic set_pin(input logic v);
        @(posedge ulpi_clk);
        #2;
        ident_open_pin = v;
        repeat (10) @(posedge ulpi_clk);
        #2;
    endtask

    // timer plus the crossing back, with margin
    task automatic wait_meas();
        repeat (MEAS / 3 + 12) @(posedge ulpi_clk);
        #2;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk_rd(CKI_ADDR_ENA_WR, CKI_ENA_RST);
        chk_rd(CKI_ADDR_STATE, 8'h00);
        chk_rd(CKI_ADDR_EVENTS, 8'h00);
        link.reg_wr(CKI_ADDR_ENA_WR, 8'hFF);
        chk_rd(CKI_ADDR_ENA_WR, 8'h23);
        chk_rd(CKI_ADDR_ENA_SET, 8'h23);
        chk_rd(CKI_ADDR_ENA_CLR, 8'h23);
        link.reg_wr(CKI_ADDR_ENA_CLR, 8'h21);
        chk_rd(CKI_ADDR_ENA_WR, 8'h02);
        link.reg_wr(CKI_ADDR_ENA_SET, 8'h01);
        chk_rd(CKI_ADDR_ENA_WR, 8'h03);
        link.reg_wr(CKI_ADDR_ENA_WR, 8'h00);
        chk_rd(CKI_ADDR_ENA_CLR, 8'h00);
    endtask

    // read-only places and unmapped vendor address 3F ignore writes
    task automatic t_ro();
        link.reg_wr(CKI_ADDR_STATE, 8'hFF);
        link.reg_wr(CKI_ADDR_EVENTS, 8'hFF);
        link.reg_wr(CKI_ADDR_VND_HI, 8'hFF);
        chk_rd(CKI_ADDR_STATE, 8'h00);
        chk_rd(CKI_ADDR_EVENTS, 8'h00);
        chk_rd(CKI_ADDR_VND_LO, 8'h00);
        chk_rd(CKI_ADDR_VND_HI, 8'h00);
        chk_alt(0);
    endtask

    task automatic t_id();
        link.reg_wr(CKI_ADDR_ENA_WR, 8'h01);
        set_pin(1'b1);
        chk_rd(CKI_ADDR_STATE, 8'h01);
        chk_alt(1);
        chk_rd(CKI_ADDR_EVENTS, 8'h01);
        chk_rd(CKI_ADDR_EVENTS, 8'h00);
        set_pin(1'b0);
        chk_alt(0);
        chk_rd(CKI_ADDR_EVENTS, 8'h00);
        link.reg_wr(CKI_ADDR_ENA_WR, 8'h02);
        set_pin(1'b1);
        chk_rd(CKI_ADDR_EVENTS, 8'h00);
        set_pin(1'b0);
        chk_alt(1);
        chk_rd(CKI_ADDR_STATE, 8'h00);
        chk_rd(CKI_ADDR_EVENTS, 8'h01);
    endtask

    // first run enabled from 1D, second from the vendor bit only
    task automatic t_meas();
        rid_code_pin = 3'h5;
        link.reg_wr(CKI_ADDR_ENA_WR, 8'h20);
        link.reg_wr(CKI_ADDR_VND_WR, 8'h10);
        wait_meas();
        chk_rd(CKI_ADDR_STATE, 8'h68);
        chk_rd(CKI_ADDR_STATE, 8'h68);
        chk_alt(1);
        chk_rd(CKI_ADDR_EVENTS, 8'h08);
        chk_rd(CKI_ADDR_VND_WR, 8'h0D);
        chk_rd(CKI_ADDR_VND_WR, 8'h05);
        chk_rd(CKI_ADDR_STATE, 8'h28);
        rid_code_pin = 3'h7;
        link.reg_wr(CKI_ADDR_ENA_WR, 8'h00);
        link.reg_wr(CKI_ADDR_VND_SET, 8'h50);
        wait_meas();
        chk_alt(1);
        chk_rd(CKI_ADDR_EVENTS, 8'h08);
        chk_rd(CKI_ADDR_VND_CLR, 8'h4F);
        chk_rd(CKI_ADDR_STATE, 8'h38);
        link.reg_wr(CKI_ADDR_VND_CLR, 8'h40);
        chk_rd(CKI_ADDR_VND_WR, 8'h07);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic stop_test();
        `CHK("handshake misses", 0, link.miss)
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // generous against some forty-four accesses of a dozen link cycles
    initial begin
        #400000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge ulpi_clk);
        #2;
        rst_n = 1'b1;
        ulpi_rst_n = 1'b1;
        @(posedge ulpi_clk);
        #2;
        t_regs();
        t_ro();
        t_id();
        t_meas();
        stop_test();
    end
endmodule
`default_nettype wire
